// ===== verilog/tcic_timer.sv
// 16-bit bidirectional timer counter with shared high-byte latch and
// input capture. Assumes an external prescaler supplies timer_tick as
// a one-cycle enable, and the CPU issues one byte strobe per cycle.
`timescale 1ns/1ps

// Function
// - High-byte accesses go through shared latch
// - Count low read copies high into latch
// - Count low write loads latch plus byte
// - Tick select: any nonzero value passes timer_tick; zero stops
// - Counter accessible with or without tick
// - CPU write beats clear or count
// - Each tick clears, increments or decrements
// - Mode field split across two controls
// - Overflow flag set per mode, interrupts
// - TOP and BOTTOM indications from count
// - Matching edge copies count into capture
// - Capture flag set with the store
// - Flag interrupts; cleared by service or one
// - Capture low read latches captured high
// - Capture writable only when it is TOP
// - Trigger from pin or comparator output
// - Capture input off when capture is TOP
// - Filter needs four equal samples
// - Filter enable inserts it; system clocked
// - Fixed bottom, max and mode TOP values
module tcic_timer
  import tcic_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // CPU byte strobes and data
  input  wire logic                  cnt_low_rd,
  input  wire logic                  cnt_high_rd,
  input  wire logic                  cnt_low_wr,
  input  wire logic                  cnt_high_wr,
  input  wire logic                  cap_low_rd,
  input  wire logic                  cap_high_rd,
  input  wire logic                  cap_low_wr,
  input  wire logic                  cap_high_wr,
  input  wire logic [BYTE_W-1:0]     wr_data,
  output logic      [BYTE_W-1:0]     rd_data,
  // Control fields
  input  wire logic [2:0]            tick_source_select,
  input  wire logic [1:0]            waveform_mode_a,
  input  wire logic [1:0]            waveform_mode_b,
  input  wire logic [COUNT_W-1:0]    compare_a_value,
  input  wire logic                  timer_tick,
  // Capture and overflow controls
  input  wire logic                  comparator_capture_select,
  input  wire logic                  capture_edge_select,
  input  wire logic                  noise_filter_enable,
  input  wire logic                  capture_irq_enable,
  input  wire logic                  capture_flag_clear,
  input  wire logic                  capture_irq_ack,
  input  wire logic                  overflow_irq_enable,
  input  wire logic                  overflow_flag_clear,
  input  wire logic                  overflow_irq_ack,
  // Trigger inputs
  input  wire logic                  capture_input_pin,
  input  wire logic                  comparator_output,
  // Status outputs
  output logic      [COUNT_W-1:0]    timer_count,
  output logic      [COUNT_W-1:0]    capture_value,
  output logic                       top_reached,
  output logic                       bottom_reached,
  output logic                       count_down,
  output logic                       overflow_flag,
  output logic                       capture_flag,
  output logic                       overflow_irq,
  output logic                       capture_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0]  temp_reg;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] top_value;
  logic [3:0]         waveform_mode_field;
  tcic_dir_type       dir_reg;
  tcic_dir_type       dir_next;
  logic               tick_active;
  logic               dual_slope;
  logic               cap_is_top;
  logic               fixed_max;
  logic               ovf_event;
  logic               pin_sync;
  logic               comp_sync;
  logic               trig_raw;
  logic               trig_filt;
  logic               trig_clean;
  logic               trig_prev_reg;
  logic               cap_event;
  logic               cap_flag_next;
  logic               ovf_flag_next;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Mode field joins the A and B control halves
  assign waveform_mode_field = {waveform_mode_b, waveform_mode_a};

  // Stopped source suppresses every tick
  assign tick_active = timer_tick && (tick_source_select != TICK_STOPPED);

  // Sequence maximum and slope for the current mode
  always_comb begin
    top_value  = MAX_VALUE;
    dual_slope = 1'b0;
    cap_is_top = 1'b0;
    fixed_max  = 1'b0;
    unique case (waveform_mode_field)
      MODE_PC_8BIT:    begin top_value = TOP_8BIT;        dual_slope = 1'b1; end
      MODE_PC_9BIT:    begin top_value = TOP_9BIT;        dual_slope = 1'b1; end
      MODE_PC_10BIT:   begin top_value = TOP_10BIT;       dual_slope = 1'b1; end
      MODE_CTC_CMPA:   begin top_value = compare_a_value; fixed_max  = 1'b1; end
      MODE_FAST_8BIT:  top_value = TOP_8BIT;
      MODE_FAST_9BIT:  top_value = TOP_9BIT;
      MODE_FAST_10BIT: top_value = TOP_10BIT;
      MODE_PFC_CAP, MODE_PC_CAP: begin
        top_value  = capture_value;
        dual_slope = 1'b1;
        cap_is_top = 1'b1;
      end
      MODE_PFC_CMPA, MODE_PC_CMPA: begin
        top_value  = compare_a_value;
        dual_slope = 1'b1;
      end
      MODE_CTC_CAP: begin
        top_value  = capture_value;
        cap_is_top = 1'b1;
        fixed_max  = 1'b1;
      end
      MODE_FAST_CAP: begin
        top_value  = capture_value;
        cap_is_top = 1'b1;
      end
      MODE_FAST_CMPA:  top_value = compare_a_value;
      default:         fixed_max = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Next count: CPU write first, then the tick's step
  always_comb begin
    count_next = timer_count;
    dir_next   = dir_reg;
    ovf_event  = 1'b0;
    if (cnt_low_wr) begin
      count_next = {temp_reg, wr_data};
      if (!dual_slope) begin
        dir_next = DIR_UP;
      end
    end else if (tick_active) begin
      if (dual_slope) begin
        unique case (dir_reg)
          DIR_UP: begin
            if (timer_count >= top_value) begin
              dir_next   = DIR_DOWN;
              count_next = timer_count - COUNT_STEP;
            end else begin
              count_next = timer_count + COUNT_STEP;
            end
          end
          DIR_DOWN: begin
            if (timer_count == BOTTOM_VALUE) begin
              dir_next   = DIR_UP;
              count_next = timer_count + COUNT_STEP;
              ovf_event  = 1'b1;
            end else begin
              count_next = timer_count - COUNT_STEP;
            end
          end
        endcase
      end else begin
        dir_next = DIR_UP;
        if (timer_count == top_value) begin
          count_next = BOTTOM_VALUE;
          ovf_event  = !fixed_max || (timer_count == MAX_VALUE);
        end else begin
          count_next = timer_count + COUNT_STEP;
          ovf_event  = timer_count == MAX_VALUE;
        end
      end
    end
  end

  // Count value and direction
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_count <= BOTTOM_VALUE;
      dir_reg     <= DIR_UP;
    end else begin
      timer_count <= count_next;
      dir_reg     <= dir_next;
    end
  end

  // TOP and BOTTOM indications track the stored count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      top_reached    <= 1'b0;
      bottom_reached <= 1'b1;
      count_down     <= 1'b0;
    end else begin
      top_reached    <= count_next == top_value;
      bottom_reached <= count_next == BOTTOM_VALUE;
      count_down     <= dir_next == DIR_DOWN;
    end
  end

  // ----------------------------------------------------------------
  // Shared high-byte latch and read data
  // ----------------------------------------------------------------
  // High writes load the latch; low reads fill it from the high byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      temp_reg <= '0;
    end else if (cnt_high_wr || cap_high_wr) begin
      temp_reg <= wr_data;
    end else if (cnt_low_rd) begin
      temp_reg <= timer_count[COUNT_W-1:BYTE_W];
    end else if (cap_low_rd) begin
      temp_reg <= capture_value[COUNT_W-1:BYTE_W];
    end
  end

  // Read data register, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (cnt_low_rd) begin
      rd_data <= timer_count[BYTE_W-1:0];
    end else if (cap_low_rd) begin
      rd_data <= capture_value[BYTE_W-1:0];
    end else if (cnt_high_rd || cap_high_rd) begin
      rd_data <= temp_reg;
    end
  end

  // ----------------------------------------------------------------
  // Capture trigger path
  // ----------------------------------------------------------------
  tcic_sync2 u_pin_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (capture_input_pin),
    .sync_out (pin_sync)
  );

  tcic_sync2 u_comp_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (comparator_output),
    .sync_out (comp_sync)
  );

  // Source choice, then optional filter on the system clock
  assign trig_raw = comparator_capture_select ? comp_sync : pin_sync;

  tcic_noise_filter u_filter (
    .clock        (clock),
    .rst_n        (rst_n),
    .sample_in    (trig_raw),
    .filtered_out (trig_filt)
  );

  assign trig_clean = noise_filter_enable ? trig_filt : trig_raw;

  // Edge detector history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_clean;
    end
  end

  // Matching edge, ignored while capture defines TOP
  assign cap_event = !cap_is_top && (trig_clean != trig_prev_reg) &&
                     (trig_clean == capture_edge_select);

  // Capture register: time stamp or CPU TOP write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      capture_value <= '0;
    end else if (cap_event) begin
      capture_value <= timer_count;
    end else if (cap_low_wr && cap_is_top) begin
      capture_value <= {temp_reg, wr_data};
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------------------------------
  // Set wins over service or write-one clear
  assign cap_flag_next = cap_event ||
                         (capture_flag && !capture_flag_clear && !capture_irq_ack);
  assign ovf_flag_next = ovf_event ||
                         (overflow_flag && !overflow_flag_clear && !overflow_irq_ack);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      capture_flag  <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      capture_flag  <= cap_flag_next;
      overflow_flag <= ovf_flag_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      capture_irq  <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      capture_irq  <= cap_flag_next && capture_irq_enable;
      overflow_irq <= ovf_flag_next && overflow_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_raw_high_run;
    (noise_filter_enable && trig_raw) [*4];
  endsequence

  sequence s_raw_low_run;
    (noise_filter_enable && !trig_raw) [*4];
  endsequence

  a_low_read_latch: assert property (@(posedge clock) disable iff (!rst_n)
    cnt_low_rd && !cnt_high_wr && !cap_high_wr
      |=> temp_reg == $past(timer_count[COUNT_W-1:BYTE_W]))
    else $error("count low read did not fill latch");

  a_high_read_latch: assert property (@(posedge clock) disable iff (!rst_n)
    (cnt_high_rd || cap_high_rd) && !cnt_low_rd && !cap_low_rd
      |=> rd_data == $past(temp_reg))
    else $error("high byte read did not return latch");

  a_low_write_load: assert property (@(posedge clock) disable iff (!rst_n)
    cnt_low_wr |=> timer_count == $past({temp_reg, wr_data}))
    else $error("16-bit counter write not applied");

  a_stopped_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (tick_source_select == TICK_STOPPED) && !cnt_low_wr |=> $stable(timer_count))
    else $error("counter moved while stopped");

  a_normal_step: assert property (@(posedge clock) disable iff (!rst_n)
    tick_active && !cnt_low_wr && (waveform_mode_field == MODE_NORMAL)
      |=> timer_count == $past(timer_count) + COUNT_STEP)
    else $error("normal mode did not increment");

  a_bottom_flag: assert property (@(posedge clock) disable iff (!rst_n)
    bottom_reached == (timer_count == BOTTOM_VALUE))
    else $error("bottom indication wrong");

  a_capture_store: assert property (@(posedge clock) disable iff (!rst_n)
    cap_event |=> capture_value == $past(timer_count) && capture_flag)
    else $error("capture did not store count and flag");

  a_capture_irq: assert property (@(posedge clock) disable iff (!rst_n)
    capture_irq == (capture_flag && $past(capture_irq_enable)))
    else $error("capture interrupt does not follow flag");

  a_flag_service: assert property (@(posedge clock) disable iff (!rst_n)
    (capture_irq_ack || capture_flag_clear) && !cap_event |=> !capture_flag)
    else $error("capture flag not cleared");

  a_cap_write_gate: assert property (@(posedge clock) disable iff (!rst_n)
    cap_low_wr && !cap_is_top && !cap_event |=> $stable(capture_value))
    else $error("capture written outside TOP mode");

  a_top_no_capture: assert property (@(posedge clock) disable iff (!rst_n)
    cap_is_top ##1 cap_is_top |=> $stable(capture_flag) || !capture_flag)
    else $error("capture flag set while capture is TOP");

  a_filter_rise: assert property (@(posedge clock) disable iff (!rst_n)
    s_raw_high_run |=> trig_filt)
    else $error("filter did not rise after four samples");

  a_filter_fall: assert property (@(posedge clock) disable iff (!rst_n)
    s_raw_low_run |=> !trig_filt)
    else $error("filter did not fall after four samples");

endmodule

// ===== include/tcic_pkg.sv
// Shared constants for the 16-bit timer counter with input capture.
// Assumes a single system clock and byte-wide CPU access strobes.
package tcic_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed count values
  // ----------------------------------------------------------------
  localparam int         BYTE_W        = 8;
  localparam int         COUNT_W       = 16;
  localparam int         FILTER_LEN    = 4;
  localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
  localparam logic [15:0] MAX_VALUE    = 16'hffff;
  localparam logic [15:0] TOP_8BIT     = 16'h00ff;
  localparam logic [15:0] TOP_9BIT     = 16'h01ff;
  localparam logic [15:0] TOP_10BIT    = 16'h03ff;
  localparam logic [15:0] COUNT_STEP   = 16'h0001;
  localparam logic [2:0]  TICK_STOPPED = 3'h0;

  // ----------------------------------------------------------------
  // Waveform mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL     = 4'h0;
  localparam logic [3:0] MODE_PC_8BIT    = 4'h1;
  localparam logic [3:0] MODE_PC_9BIT    = 4'h2;
  localparam logic [3:0] MODE_PC_10BIT   = 4'h3;
  localparam logic [3:0] MODE_CTC_CMPA   = 4'h4;
  localparam logic [3:0] MODE_FAST_8BIT  = 4'h5;
  localparam logic [3:0] MODE_FAST_9BIT  = 4'h6;
  localparam logic [3:0] MODE_FAST_10BIT = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP    = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA   = 4'h9;
  localparam logic [3:0] MODE_PC_CAP     = 4'ha;
  localparam logic [3:0] MODE_PC_CMPA    = 4'hb;
  localparam logic [3:0] MODE_CTC_CAP    = 4'hc;
  localparam logic [3:0] MODE_RESERVED   = 4'hd;
  localparam logic [3:0] MODE_FAST_CAP   = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA  = 4'hf;

  // Count direction
  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } tcic_dir_type;

endpackage

// ===== verilog/tcic_sync2.sv
// Two-stage level synchroniser.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps

module tcic_sync2 (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1_reg;

  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1_reg <= 1'b0;
      sync_out   <= 1'b0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// ===== verilog/tcic_noise_filter.sv
// Majority-free noise filter: output follows only a run of equal samples.
// Assumes a synchronised input sampled on every system clock.
`timescale 1ns/1ps

module tcic_noise_filter
  import tcic_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Sample in, filtered level out
  input  wire logic sample_in,
  output logic      filtered_out
);

  logic [FILTER_LEN-2:0] hist_reg;
  logic [FILTER_LEN-1:0] window;

  assign window = {hist_reg, sample_in};

  // Sample history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= window[FILTER_LEN-2:0];
    end
  end

  // Output moves only when the whole window agrees
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      filtered_out <= 1'b0;
    end else if (&window) begin
      filtered_out <= 1'b1;
    end else if (~|window) begin
      filtered_out <= 1'b0;
    end
  end

endmodule

// ===== tb/tcic_cpu_model.sv
// CPU-side model: drives the byte strobes and write data toward the timer.
// Assumes the bench calls its tasks; strobes change only on falling edges.
`timescale 1ns/1ps

module tcic_cpu_model (
  // Clock
  input  wire logic                        clock,
  // Strobes: cnt lo rd, hi rd, lo wr, hi wr, then the same for capture
  output logic      [7:0]                  strobe,
  output logic      [tcic_pkg::BYTE_W-1:0] wr_data,
  // Read return
  input  wire logic [tcic_pkg::BYTE_W-1:0] rd_data
);
  import tcic_pkg::*;

  // Idle bus at time zero
  initial begin
    strobe  = 8'h00;
    wr_data = 8'h5a;
  end

  // One strobe for one cycle; a released data line shows the inverse value
  task automatic op(input int idx, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    strobe[idx] = 1'b1;
    wr_data     = d;
    @(negedge clock);
    strobe  = 8'h00;
    wr_data = ~d;
    q       = rd_data;
  endtask

  // Word write, high byte first (sel 0 counter, 1 capture)
  task automatic write16(input int sel, input logic [15:0] v);
    logic [7:0] q;
    op(sel * 4 + 3, v[15:8], q);
    op(sel * 4 + 2, v[7:0], q);
  endtask

  // Low byte only, reusing the high byte already in the latch
  task automatic write_low(input int sel, input logic [7:0] b);
    logic [7:0] q;
    op(sel * 4 + 2, b, q);
  endtask

  // Word read, low byte first
  task automatic read16(input int sel, output logic [15:0] v);
    op(sel * 4, 8'h00, v[7:0]);
    op(sel * 4 + 1, 8'h00, v[15:8]);
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the 16-bit timer with input capture.
// Assumes tcic_cpu_model drives the byte strobes; other inputs are driven here.
`timescale 1ns/1ps

module tb;
  import tcic_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        clock, rst_n, tick, ccs, esel, nfe, cie, cfc, cia, oie, ofc, oia, pin, cmp;
  logic [7:0]  strobe, wr_data, rd_data, d;
  logic [2:0]  tsel;
  logic [1:0]  ma, mb;
  logic [15:0] cnt, cap, v, cmpa;
  logic        top, bot, down, ovf, capf, ovf_irq, cap_irq;
  int          err_total, n_compared, cycles;

  tcic_cpu_model i_cpu (.clock(clock), .strobe(strobe), .wr_data(wr_data), .rd_data(rd_data));

  tcic_timer i_dut (
    .clock(clock), .rst_n(rst_n),
    .cnt_low_rd(strobe[0]), .cnt_high_rd(strobe[1]), .cnt_low_wr(strobe[2]),
    .cnt_high_wr(strobe[3]), .cap_low_rd(strobe[4]), .cap_high_rd(strobe[5]),
    .cap_low_wr(strobe[6]), .cap_high_wr(strobe[7]), .wr_data(wr_data), .rd_data(rd_data),
    .tick_source_select(tsel), .waveform_mode_a(ma), .waveform_mode_b(mb),
    .compare_a_value(cmpa), .timer_tick(tick),
    .comparator_capture_select(ccs), .capture_edge_select(esel),
    .noise_filter_enable(nfe), .capture_irq_enable(cie), .capture_flag_clear(cfc),
    .capture_irq_ack(cia), .overflow_irq_enable(oie), .overflow_flag_clear(ofc),
    .overflow_irq_ack(oia), .capture_input_pin(pin), .comparator_output(cmp),
    .timer_count(cnt), .capture_value(cap), .top_reached(top), .bottom_reached(bot),
    .count_down(down), .overflow_flag(ovf), .capture_flag(capf),
    .overflow_irq(ovf_irq), .capture_irq(cap_irq)
  );

  // 10 MHz system clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Timer ticks one cycle wide, then one settling cycle
  task automatic tick_n(input int n);
    repeat (n) begin
      @(negedge clock);
      tick = 1'b1;
      @(negedge clock);
      tick = 1'b0;
    end
    @(negedge clock);
  endtask

  task automatic set_mode(input logic [3:0] m);
    @(negedge clock);
    mb = m[3:2];
    ma = m[1:0];
  endtask

  // Pulse one of the flag clear or acknowledge inputs (0 cfc, 1 cia, 2 ofc, 3 oia)
  task automatic pulse(input int k);
    @(negedge clock);
    {oia, ofc, cia, cfc} = 4'h1 << k;
    @(negedge clock);
    {oia, ofc, cia, cfc} = 4'h0;
    @(negedge clock);
  endtask

  // Change a trigger level, then wait a number of cycles
  task automatic trig(input bit use_cmp, input logic lvl, input int n);
    @(negedge clock);
    if (use_cmp) begin
      cmp = lvl;
    end else begin
      pin = lvl;
    end
    repeat (n) @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_access;
    chk("bottom after reset", 16'h1, {15'h0, bot});
    i_cpu.write16(0, 16'h01ff);
    chk("count write", 16'h01ff, cnt);
    tick_n(2);
    chk("stopped count", 16'h01ff, cnt);
    i_cpu.read16(0, v);
    chk("count read", 16'h01ff, v);
    i_cpu.op(3, 8'h77, d);
    chk("high write via latch", 16'h01ff, cnt);
    i_cpu.write_low(0, 8'h00);
    chk("low write joins latch", 16'h7700, cnt);
    $display("test access done");
  endtask

  task automatic t_count;
    tsel = 3'h1;
    tick_n(3);
    chk("count up", 16'h7703, cnt);
    i_cpu.write16(0, 16'hffff);
    tick_n(1);
    chk("wrap at max", 16'h0000, cnt);
    chk("overflow flag", 16'h1, {15'h0, ovf});
    chk("overflow irq", 16'h1, {15'h0, ovf_irq});
    pulse(3);
    chk("overflow ack", 16'h0, {15'h0, ovf});
    i_cpu.op(3, 8'h12, d);
    fork
      i_cpu.write_low(0, 8'h34);
      tick_n(1);
    join
    chk("write beats tick", 16'h1234, cnt);
    for (int i = 0; i < 3; i++) begin
      set_mode(4'h5 + 4'(i));
      i_cpu.write16(0, (16'h0100 << i) - 16'h1);
      tick_n(1);
      chk("fast wrap at top", 16'h0000, cnt);
    end
    set_mode(MODE_CTC_CMPA);
    cmpa = 16'h0010;
    i_cpu.write16(0, 16'h0010);
    tick_n(1);
    chk("compare top wrap", 16'h0000, cnt);
    $display("test count done");
  endtask

  task automatic t_dual;
    set_mode(MODE_PC_8BIT);
    pulse(2);
    i_cpu.write16(0, 16'h00fe);
    tick_n(1);
    chk("top reached", 16'h1, {15'h0, top});
    tick_n(1);
    chk("turn down", 16'h00fe, cnt);
    chk("down flag", 16'h1, {15'h0, down});
    i_cpu.write16(0, 16'h0001);
    tick_n(1);
    chk("bottom reached", 16'h1, {15'h0, bot});
    chk("no overflow yet", 16'h0, {15'h0, ovf});
    tick_n(1);
    chk("leave bottom", 16'h0001, cnt);
    chk("overflow at bottom", 16'h1, {15'h0, ovf});
    $display("test dual slope done");
  endtask

  task automatic t_capture;
    set_mode(MODE_NORMAL);
    tsel = 3'h0;
    i_cpu.write16(0, 16'h4321);
    trig(0, 1'b1, 6);
    chk("capture rising", 16'h4321, cap);
    chk("capture flag", 16'h1, {15'h0, capf});
    chk("capture irq", 16'h1, {15'h0, cap_irq});
    pulse(1);
    chk("flag ack", 16'h0, {15'h0, capf});
    i_cpu.read16(1, v);
    chk("capture read", 16'h4321, v);
    esel = 1'b0;
    i_cpu.write16(0, 16'h0abc);
    trig(0, 1'b0, 6);
    chk("capture falling", 16'h0abc, cap);
    pulse(0);
    chk("flag write clear", 16'h0, {15'h0, capf});
    ccs = 1'b1;
    esel = 1'b1;
    pulse(0);
    i_cpu.write16(0, 16'h0def);
    trig(1, 1'b1, 6);
    chk("comparator source", 16'h0def, cap);
    cie = 1'b0;
    @(negedge clock);
    chk("irq masked", 16'h0, {15'h0, cap_irq});
    nfe = 1'b1;
    esel = 1'b0;
    i_cpu.write16(0, 16'h0555);
    trig(1, 1'b0, 4);
    chk("filter delay", 16'h0def, cap);
    repeat (6) @(negedge clock);
    chk("filtered capture", 16'h0555, cap);
    $display("test capture done");
  endtask

  task automatic t_capmode;
    set_mode(MODE_CTC_CAP);
    {nfe, ccs, esel} = 3'b001;
    pulse(0);
    i_cpu.write16(1, 16'h1234);
    chk("capture write", 16'h1234, cap);
    i_cpu.write_low(1, 8'h56);
    chk("latch reuse", 16'h1256, cap);
    trig(0, 1'b1, 6);
    chk("input off when top", 16'h1256, cap);
    chk("no flag when top", 16'h0, {15'h0, capf});
    set_mode(MODE_NORMAL);
    i_cpu.write16(1, 16'hbeef);
    chk("capture write refused", 16'h1256, cap);
    $display("test capture top done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, well above the fewer than 200 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    {rst_n, tick, ccs, nfe, cie, cfc, cia, oie, ofc, oia, pin, cmp} = 12'h0;
    {esel, cie, oie} = 3'b111;
    {tsel, ma, mb} = 7'h0;
    cmpa = 16'h0100;
    {err_total, n_compared, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_access();
    t_count();
    t_dual();
    t_capture();
    t_capmode();
    conclude();
  end
endmodule
